// File: verilog/tdma_defs.vh
// Constants for the table read and data memory access block
`ifndef TDMA_DEFS_VH
`define TDMA_DEFS_VH
`define TDMA_ADDR_IND      8'h00
`define TDMA_ADDR_MP       8'h01
`define TDMA_ADDR_TPTR     8'h07
`define TDMA_ADDR_THIGH    8'h08
`define TDMA_GP_BASE       8'h40
`define TDMA_ZERO_BYTE     8'h00
`define TDMA_MP_BIT7       7
`define TDMA_OP_NONE       3'h0
`define TDMA_OP_READ       3'h1
`define TDMA_OP_WRITE      3'h2
`define TDMA_OP_BSET       3'h3
`define TDMA_OP_BCLR       3'h4
`define TDMA_OP_TRD_CUR    3'h5
`define TDMA_OP_TRD_LAST   3'h6
`endif

// File: verilog/tdma_addr_gen.v
// Table word address former for both table read forms
`timescale 1ns/1ps
module tdma_addr_gen #(
  parameter PW = 12
) (
  input  wire [PW-1:0] pc_i,
  input  wire [7:0]    tptr_i,
  input  wire          last_i,
  output wire [PW-1:0] addr_o
);
  wire [PW-9:0] upper;
  // Last page forces every implemented upper bit high
  assign upper  = last_i ? {(PW-8){1'b1}} : pc_i[PW-1:8];
  assign addr_o = {upper, tptr_i};
endmodule // tdma_addr_gen

// File: verilog/tdma_gp_ram.v
// General purpose data memory, flip-flop storage
`timescale 1ns/1ps
module tdma_gp_ram #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [7:0]    wdata_i,
  input  wire [AW-1:0] raddr_i,
  output wire [7:0]    rdata_o
);
  reg [7:0] mem_q [0:DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_cell
      // No reset: contents are undefined at power-up like real RAM
      always @(posedge clk_i) begin
        if (we_i && (waddr_i == g)) begin
          mem_q[g] <= wdata_i;
        end
      end
    end
  endgenerate
  assign rdata_o = mem_q[raddr_i];
endmodule // tdma_gp_ram

// File: verilog/tdma_top.v
// Table read and data memory access logic of the core
`timescale 1ns/1ps
`include "tdma_defs.vh"
module tdma_top #(
  parameter PW       = 12,
  parameter PROM_W   = 15,
  parameter GP_DEPTH = 64,
  parameter GP_AW    = 6,
  parameter MP_BIT7  = 0
) (
  input  wire          CORE_CLK_I,
  input  wire          RST_I,
  input  wire [2:0]    OP_I,
  input  wire [7:0]    ADDR_I,
  input  wire [7:0]    WDATA_I,
  input  wire [2:0]    BIT_I,
  input  wire [PW-1:0] PC_I,
  input  wire [PROM_W-1:0] PROM_DATA_I,
  output reg  [7:0]    RDATA_O,
  output reg           RVALID_O,
  output reg           BUSY_O,
  output reg  [PW-1:0] PROM_ADDR_O,
  output reg           PROM_RD_O,
  output reg  [7:0]    TPTR_O,
  output reg  [7:0]    THIGH_O
);
  localparam ST_IDLE = 1'b0;
  localparam ST_TRD2 = 1'b1;
  localparam [7:0] MP_FORCE = MP_BIT7 ? 8'h80 : 8'h00;

  reg          state_q;
  reg [7:0]    mp_q;
  reg [7:0]    tptr_q;
  reg [7:0]    thigh_q;
  reg [7:0]    dest_q;
  reg          last_q;

  wire [PW-1:0] taddr;
  wire [7:0]    gp_rdata;
  wire [7:0]    mp_read;
  reg  [7:0]    eff_addr;
  reg           ind_self;
  reg  [7:0]    rd_byte;
  reg  [7:0]    wr_byte;
  reg           wr_en;
  reg  [7:0]    wr_addr;
  reg  [15:0]   word_ext;

  assign mp_read = mp_q | MP_FORCE;

  tdma_addr_gen #(
    .PW(PW)
  ) u_addr (
    .pc_i   (PC_I),
    .tptr_i (tptr_q),
    .last_i (OP_I == `TDMA_OP_TRD_LAST),
    .addr_o (taddr)
  );

  // Resolve indirect port through the pointer
  always @* begin
    ind_self = 1'b0;
    eff_addr = ADDR_I;
    if (ADDR_I == `TDMA_ADDR_IND) begin
      eff_addr = mp_read;
      ind_self = (mp_read == `TDMA_ADDR_IND);
    end
  end

  // Read mux; unmapped special locations give zero
  always @* begin
    rd_byte = `TDMA_ZERO_BYTE;
    if (ind_self) begin
      rd_byte = `TDMA_ZERO_BYTE;
    end else if (eff_addr >= `TDMA_GP_BASE) begin
      if (eff_addr < `TDMA_GP_BASE + GP_DEPTH) begin
        rd_byte = gp_rdata;
      end
    end else begin
      case (eff_addr)
        `TDMA_ADDR_MP:    rd_byte = mp_read;
        `TDMA_ADDR_TPTR:  rd_byte = tptr_q;
        `TDMA_ADDR_THIGH: rd_byte = thigh_q;
        default:          rd_byte = `TDMA_ZERO_BYTE;
      endcase
    end
  end

  // Whole table word, zero padded above the word width
  always @* begin
    word_ext = 16'h0000;
    word_ext[PROM_W-1:0] = PROM_DATA_I;
  end

  // Write path for direct, indirect, bit and table writes
  always @* begin
    wr_en   = 1'b0;
    wr_addr = eff_addr;
    wr_byte = WDATA_I;
    if (state_q == ST_TRD2) begin
      wr_en   = 1'b1;
      wr_addr = dest_q;
      wr_byte = word_ext[7:0];
    end else if (!ind_self) begin
      case (OP_I)
        `TDMA_OP_WRITE: wr_en = 1'b1;
        `TDMA_OP_BSET: begin
          wr_en   = 1'b1;
          wr_byte = rd_byte | (8'h01 << BIT_I);
        end
        `TDMA_OP_BCLR: begin
          wr_en   = 1'b1;
          wr_byte = rd_byte & ~(8'h01 << BIT_I);
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  tdma_gp_ram #(
    .DEPTH(GP_DEPTH),
    .AW(GP_AW)
  ) u_ram (
    .clk_i   (CORE_CLK_I),
    .we_i    (wr_en && (wr_addr >= `TDMA_GP_BASE)
              && (wr_addr < `TDMA_GP_BASE + GP_DEPTH)),
    .waddr_i (wr_addr[GP_AW-1:0]),
    .wdata_i (wr_byte),
    .raddr_i (eff_addr[GP_AW-1:0]),
    .rdata_o (gp_rdata)
  );

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q     <= ST_IDLE;
      mp_q        <= 8'h00;
      tptr_q      <= 8'h00;
      thigh_q     <= 8'h00;
      dest_q      <= 8'h00;
      last_q      <= 1'b0;
      RDATA_O     <= 8'h00;
      RVALID_O    <= 1'b0;
      BUSY_O      <= 1'b0;
      PROM_ADDR_O <= {PW{1'b0}};
      PROM_RD_O   <= 1'b0;
      TPTR_O      <= 8'h00;
      THIGH_O     <= 8'h00;
    end else begin
      RVALID_O  <= 1'b0;
      PROM_RD_O <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (OP_I == `TDMA_OP_TRD_CUR || OP_I == `TDMA_OP_TRD_LAST) begin
            // Two cycles: address out now, capture next
            state_q     <= ST_TRD2;
            dest_q      <= eff_addr;
            last_q      <= (OP_I == `TDMA_OP_TRD_LAST);
            PROM_ADDR_O <= taddr;
            PROM_RD_O   <= 1'b1;
            BUSY_O      <= 1'b1;
          end else begin
            if (OP_I == `TDMA_OP_READ) begin
              RDATA_O  <= rd_byte;
              RVALID_O <= 1'b1;
            end
            // Table high byte has no write path
            if (wr_en && wr_addr == `TDMA_ADDR_MP) begin
              mp_q <= wr_byte;
            end
            if (wr_en && wr_addr == `TDMA_ADDR_TPTR) begin
              tptr_q <= wr_byte;
            end
          end
        end
        ST_TRD2: begin
          state_q <= ST_IDLE;
          BUSY_O  <= 1'b0;
          thigh_q <= word_ext[15:8];
          // Destination may itself be a special register
          if (dest_q == `TDMA_ADDR_MP) begin
            mp_q <= word_ext[7:0];
          end
          if (dest_q == `TDMA_ADDR_TPTR) begin
            tptr_q <= word_ext[7:0];
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      TPTR_O  <= tptr_q;
      THIGH_O <= thigh_q;
    end
  end
endmodule // tdma_top

// File: sim/tdma_top_monitor.sv
// Port assertions for the table read and data memory block
`timescale 1ns/1ps
module tdma_mon #(parameter PW = 12, parameter PROM_W = 15) (
  input logic          CORE_CLK_I,
  input logic          RST_I,
  input logic [2:0]    OP_I,
  input logic [7:0]    ADDR_I,
  input logic [PW-1:0] PC_I,
  input logic [7:0]    RDATA_O,
  input logic          RVALID_O,
  input logic          BUSY_O,
  input logic [PW-1:0] PROM_ADDR_O,
  input logic          PROM_RD_O,
  input logic [7:0]    THIGH_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  wire cur = !BUSY_O && OP_I == 3'h5;
  wire last = !BUSY_O && OP_I == 3'h6;
  chk_trd_launch: assert property (cur || last |=> PROM_RD_O)
    else $error("table read not launched");
  chk_busy_single: assert property (BUSY_O |=> !BUSY_O)
    else $error("busy held too long");
  chk_fetch_pair: assert property (PROM_RD_O == BUSY_O)
    else $error("fetch and busy apart");
  chk_last_page: assert property (last |=> PROM_ADDR_O >> 8 == {(PW-8){1'b1}})
    else $error("last page bits wrong");
  chk_cur_page: assert property (cur |=> PROM_ADDR_O >> 8 == $past(PC_I) >> 8)
    else $error("current page bits wrong");
  chk_thigh_upper: assert property (THIGH_O >> (PROM_W - 8) == 8'h00)
    else $error("table high spare bits set");
  // Only a finished table read may move the high byte
  chk_thigh_ro: assert property ($changed(THIGH_O) |-> $past(BUSY_O) || $past(BUSY_O, 2))
    else $error("table high changed");
  chk_unused_zero: assert property (RVALID_O && $past(ADDR_I) inside {[8'h02:8'h06],
    [8'h09:8'h3F]} |-> RDATA_O == 8'h00)
    else $error("unused location not zero");
  cover property (last);
  cover property (cur);
  cover property (RVALID_O);
endmodule // tdma_mon
bind tdma_top tdma_mon #(.PW(PW), .PROM_W(PROM_W)) u_mon (.CORE_CLK_I(CORE_CLK_I),
  .RST_I(RST_I), .OP_I(OP_I), .ADDR_I(ADDR_I), .PC_I(PC_I), .RDATA_O(RDATA_O),
  .RVALID_O(RVALID_O), .BUSY_O(BUSY_O), .PROM_ADDR_O(PROM_ADDR_O),
  .PROM_RD_O(PROM_RD_O), .THIGH_O(THIGH_O));

// File: sim/tb_table_read_and_data_memory_access.sv
// Self-checking bench for the table read and data memory block
`timescale 1ns/1ps
module tb_table_read_and_data_memory_access;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  op = 3'h0;
  logic [2:0]  bitn = 3'h0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [11:0] pc = 12'h000;
  logic [14:0] pdata = 15'h0000;
  logic [7:0]  rdata;
  logic [7:0]  thigh;
  logic [7:0]  tptr;
  logic [11:0] paddr;
  logic        rvalid;
  logic        busy;
  logic        prd;
  int          fail_count = 0;
  int          n_tests = 0;
  always #12.5 clk = ~clk;
  tdma_top dut (.CORE_CLK_I(clk), .RST_I(rst), .OP_I(op), .ADDR_I(addr), .WDATA_I(wdata),
    .BIT_I(bitn), .PC_I(pc), .PROM_DATA_I(pdata), .RDATA_O(rdata), .RVALID_O(rvalid),
    .BUSY_O(busy), .PROM_ADDR_O(paddr), .PROM_RD_O(prd), .TPTR_O(tptr), .THIGH_O(thigh));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Bit index rides in the data byte to keep calls short
  task automatic put(input logic [2:0] o, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    op <= o;
    addr <= a;
    wdata <= d;
    bitn <= d[2:0];
    @(posedge clk);
    op <= 3'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    put(3'h1, a, 8'h00);
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, exp);
  endtask
  // One thread only, so table reads never overlap
  task automatic trd(input logic [2:0] o, input logic [7:0] d, input logic [14:0] w,
                     input logic [11:0] p, input logic [11:0] ea);
    @(posedge clk);
    pdata <= w;
    pc <= p;
    put(o, d, 8'h00);
    #1;
    chk(prd, 1'b1);
    chk(paddr, ea);
    repeat (2) @(posedge clk);
    #1;
    chk(thigh, {1'b0, w[14:8]});
    rd(d, w[7:0]);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h08, 8'h00);
    put(3'h2, 8'h40, 8'hA5);
    put(3'h2, 8'h7F, 8'h5A);
    rd(8'h40, 8'hA5);
    rd(8'h7F, 8'h5A);
    put(3'h2, 8'h09, 8'hFF);
    rd(8'h09, 8'h00);
    put(3'h2, 8'h01, 8'h45);
    put(3'h2, 8'h00, 8'h3C);
    rd(8'h45, 8'h3C);
    rd(8'h01, 8'h45);
    put(3'h2, 8'h01, 8'h00);
    put(3'h2, 8'h00, 8'h77);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    put(3'h2, 8'h41, 8'h0F);
    put(3'h3, 8'h41, 8'h07);
    put(3'h4, 8'h41, 8'h00);
    rd(8'h41, 8'h8E);
    put(3'h2, 8'h07, 8'hA5);
    rd(8'h07, 8'hA5);
    chk(tptr, 8'hA5);
    trd(3'h5, 8'h42, 15'h1234, 12'h3C0, 12'h3A5);
    put(3'h2, 8'h08, 8'hFF);
    put(3'h3, 8'h08, 8'h07);
    rd(8'h08, 8'h12);
    put(3'h2, 8'h07, 8'h06);
    trd(3'h6, 8'h43, 15'h7F1A, 12'h123, 12'hF06);
    final_report;
  end
  initial begin
    #50000;
    fail_count++;
    final_report;
  end
endmodule // tb_table_read_and_data_memory_access
